// *** tadc_cfg.svh ***
`ifndef TADC_CFG_SVH
`define TADC_CFG_SVH

`define SYS_CLK_MHZ      100
`define TEMP_CONV_US     2200
`define VOLT_CONV_US     1100
`define WAKE_US          100
`define WAKE_INTREF_US   100
`define TIMER_W          18
`define SYNC_STAGES      2

`define CMD_BITS         8
`define RESULT_BITS      16
`define CODE_W           12

`define CFG_PREFIX       4'h0
`define CONV_PREFIX      3'h2
`define CFG_PM_HI        2
`define CFG_PM_LO        1
`define CFG_REF_BIT      0
`define CONV_SEL_HI      3

`define PM_SHUTDOWN      2'h0
`define PM_STBY_PLUS     2'h1
`define PM_STANDBY       2'h2
`define PM_NORMAL        2'h3

`define SEL_TEMP_INT     4'h7
`define SEL_TEMP_EXT1    4'hC
`define SEL_TEMP_EXT2    4'hD
`define SEL_RESET        4'h0

`endif

// *** tadc_pkg.sv ***
`include "tadc_cfg.svh"

package tadc_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAKE,
    ST_CONV_A,
    ST_CONV_B
  } conv_state_t;

  typedef struct packed {
    conv_state_t              st;
    logic [`TIMER_W-1:0]      timer;
    logic [1:0]               pm;
    logic                     ref_int;
    logic [3:0]               sel;
    logic                     is_temp;
    logic                     bias_step;
    logic [`CODE_W-1:0]       first_code;
    logic [`RESULT_BITS-1:0]  word;
    logic                     cmd_prev;
    logic                     fall_prev;
    logic                     done_tog;
    logic                     strobe_n;
    logic                     dout;
    logic                     dout_oe;
    logic                     adc_on;
    logic                     clk_on;
    logic                     ref_buf_on;
    logic                     ref_internal;
    logic                     temp_on;
  } core_state_t;

  typedef struct packed {
    logic        hunting;
    logic [2:0]  bit_cnt;
    logic [6:0]  shreg;
    logic        done_ref;
    logic [4:0]  out_cnt;
  } link_rx_t;

endpackage

// *** tadc_sync.sv ***
`timescale 1ns/1ps

module tadc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  always_comb begin
    next_s.meta = d_i;
    next_s.q    = s.meta;
  end

  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  assign q_o = s.q;

endmodule // tadc_sync

// *** tadc_link.sv ***
`timescale 1ns/1ps
`include "tadc_cfg.svh"

module tadc_link #(
  parameter int OUT_BITS = `RESULT_BITS
) (
  input  wire logic                 sclk_i,
  input  wire logic                 cs_n_i,
  input  wire logic                 din_i,
  input  wire logic                 rstn_i,
  input  wire logic                 done_tog_i,
  output logic      [`CMD_BITS-1:0] cmd_byte_o,
  output logic                      cmd_tog_o,
  output logic                      fall_tog_o
);
  import tadc_pkg::*;

  link_rx_t            r;
  link_rx_t            next_r;
  logic [`CMD_BITS-1:0] full;
  logic                is_cfg;
  logic                is_conv;
  logic                done_s;
  logic                byte_done;
  logic                pos_tog;

  tadc_sync #(.W(1)) u_done_sync (
    .clk_i (sclk_i),
    .d_i   (done_tog_i),
    .q_o   (done_s)
  );

  always_comb begin
    next_r    = r;
    full      = {r.shreg, din_i};
    is_cfg    = full[6:3] == `CFG_PREFIX;
    is_conv   = full[6:4] == `CONV_PREFIX;
    byte_done = 1'b0;
    if (r.bit_cnt != 3'h0) begin
      next_r.shreg   = full[6:0];
      next_r.bit_cnt = r.bit_cnt + 3'h1;
      if (r.bit_cnt == 3'h7) begin
        next_r.bit_cnt = 3'h0;
        byte_done      = is_cfg | is_conv; // R26
        if (is_conv) begin
          next_r.hunting  = 1'b0;
          next_r.out_cnt  = 5'h00;
          next_r.done_ref = done_s;
        end
      end
    end else if (r.hunting) begin
      if (din_i) begin // R2
        next_r.bit_cnt = 3'h1;
        next_r.shreg   = 7'h01;
      end
    end else if (done_s != r.done_ref) begin
      // Two edges are spent inside the synchroniser after the conversion ends
      next_r.out_cnt = r.out_cnt + 5'h01;
      if (r.out_cnt == 5'(OUT_BITS - `SYNC_STAGES - 1)) begin
        next_r.hunting = 1'b1; // R2
      end
    end
  end

  // Select high re-arms the start-bit hunt and blocks shifting
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin // R11
      r <= '{hunting: 1'b1, bit_cnt: 3'h0, shreg: 7'h00, done_ref: 1'b0, out_cnt: 5'h00};
    end else begin
      r <= next_r; // R1
    end
  end

  always_ff @(posedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_byte_o <= 8'h00;
      pos_tog    <= 1'b0;
    end else if (!cs_n_i && byte_done) begin
      cmd_byte_o <= full;
      pos_tog    <= ~pos_tog;
    end
  end

  // Command event and output shifting leave on the falling edge
  always_ff @(negedge sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_tog_o  <= 1'b0;
      fall_tog_o <= 1'b0;
    end else if (!cs_n_i) begin
      cmd_tog_o  <= pos_tog; // R8
      fall_tog_o <= ~fall_tog_o; // R3
    end
  end

endmodule // tadc_link

// *** temp_adc_serial_control.sv ***
// Operation
// R1 - Serial input sampled on rising serial clock only while select is low.
// R2 - Start bit hunted after select falls, a config byte, or 16 result bits.
// R3 - Serial output changes on falling clock edges, two bytes MSB first.
// R4 - Temperature word: two leading bits, 12-bit unsigned value, two zeros.
// R5 - Voltage word: sign repeated, 12-bit two's complement, sub-LSB, two zeros.
// R6 - Power-up enters shutdown with all conversion functions off.
// R7 - Host sends configuration then conversion byte; config may be skipped later.
// R8 - Strobe falls on the conversion byte's last falling edge, rises when done.
// R9 - Temperature conversion takes 2.2 ms, voltage conversion 1.1 ms.
// R10 - Result MSB out from strobe rise; later falls shift; beyond sixteen gives zeros.
// R11 - Strobe always driven; select high blocks shifting, not the conversion.
// R12 - Serial output is high impedance while select is high.
// R13 - Config byte: start, 0000, power mode in bits 2:1, reference in bit 0.
// R14 - Conversion byte: start, 010, four-bit input selection in bits 3:0.
// R15 - Power mode 00 shutdown, 01 standby-plus, 10 standby, 11 normal.
// R16 - Codes 0111, 1100, 1101 measure temperature; others measure voltage.
// R17 - Reference bit 1 selects internal reference, 0 external.
// R18 - Temperature conversions always use the internal reference.
// R19 - Standby turns everything off; wake-up 0.1 ms with external reference.
// R20 - Standby-plus keeps reference buffer on; 0.1 ms wake with internal reference.
// R21 - Shutdown turns all off and clears the result register.
// R22 - Temperature result is the difference of two bias-step conversions.
// R23 - Temperature result LSB equals one eighth of a kelvin.
// R24 - Host is master, serial clock at most 2.5 MHz, mode 0. The test host clocks at 6.25 MHz (80 ns half period).
// R25 - Host should hold serial clock low while the strobe is low.
// R26 - Bytes matching neither command prefix are ignored, settings unchanged.
`timescale 1ns/1ps
`include "tadc_cfg.svh"

module temp_adc_serial_control #(
  parameter int unsigned TEMP_CONV_CYCLES   = `TEMP_CONV_US * `SYS_CLK_MHZ,
  parameter int unsigned VOLT_CONV_CYCLES   = `VOLT_CONV_US * `SYS_CLK_MHZ,
  parameter int unsigned WAKE_CYCLES        = `WAKE_US * `SYS_CLK_MHZ,
  parameter int unsigned WAKE_INTREF_CYCLES = `WAKE_INTREF_US * `SYS_CLK_MHZ
) (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       sclk_i,
  input  wire logic                       cs_n_i,
  input  wire logic                       din_i,
  input  wire logic [`CODE_W-1:0]         adc_code_i,
  input  wire logic                       adc_sub_lsb_i,
  output logic                            dout_o,
  output logic                            dout_oe_o,
  output logic                            conversion_strobe_n_o,
  output logic      [1:0]                 power_mode_o,
  output logic      [3:0]                 input_select_o,
  output logic                            adc_on_o,
  output logic                            int_clk_on_o,
  output logic                            ref_buffer_on_o,
  output logic                            ref_internal_o,
  output logic                            temp_circuit_on_o,
  output logic                            bias_step_o
);
  import tadc_pkg::*;

  localparam logic [`TIMER_W-1:0] TEMP_HALF = `TIMER_W'(TEMP_CONV_CYCLES / 2);
  localparam logic [`TIMER_W-1:0] VOLT_LEN  = `TIMER_W'(VOLT_CONV_CYCLES);
  localparam logic [`TIMER_W-1:0] WAKE_LEN  = `TIMER_W'(WAKE_CYCLES);
  localparam logic [`TIMER_W-1:0] WAKE_IREF = `TIMER_W'(WAKE_INTREF_CYCLES);

  core_state_t          s;
  core_state_t          next_s;
  logic [`CMD_BITS-1:0] cmd_byte;
  logic                 cmd_tog;
  logic                 fall_tog;
  logic [2:0]           sync_q;
  logic                 cs_s;
  logic                 cmd_s;
  logic                 fall_s;
  logic                 cmd_evt;
  logic                 fall_evt;
  logic                 busy;
  logic                 normal;
  logic                 ref_eff;
  logic [`CODE_W-1:0]   temp_diff;
  logic                 sel_temp;

  tadc_link #(.OUT_BITS(`RESULT_BITS)) u_link (
    .sclk_i     (sclk_i),
    .cs_n_i     (cs_n_i),
    .din_i      (din_i),
    .rstn_i     (rstn_i),
    .done_tog_i (s.done_tog),
    .cmd_byte_o (cmd_byte),
    .cmd_tog_o  (cmd_tog),
    .fall_tog_o (fall_tog)
  );

  tadc_sync #(.W(3)) u_sync (
    .clk_i (sys_clk_i),
    .d_i   ({cs_n_i, cmd_tog, fall_tog}),
    .q_o   (sync_q)
  );

  assign cs_s   = sync_q[2];
  assign cmd_s  = sync_q[1];
  assign fall_s = sync_q[0];

  always_comb begin
    next_s    = s;
    cmd_evt   = cmd_s != s.cmd_prev;
    fall_evt  = (fall_s != s.fall_prev) && !cs_s;
    temp_diff = adc_code_i - s.first_code; // R22
    sel_temp  = 1'b0;
    busy      = 1'b0;
    normal    = 1'b0;
    ref_eff   = 1'b0;

    next_s.cmd_prev  = cmd_s;
    next_s.fall_prev = fall_s;

    // Each falling edge moves the next bit up; zeros fill behind
    if (fall_evt) begin
      next_s.word = {s.word[`RESULT_BITS-2:0], 1'b0}; // R10
    end

    if (s.st != ST_IDLE && s.timer != '0) begin
      next_s.timer = s.timer - `TIMER_W'(1);
    end

    case (s.st)
      ST_IDLE: begin
      end
      ST_WAKE: begin
        if (s.timer == '0) begin
          next_s.st    = ST_CONV_A;
          next_s.timer = s.is_temp ? TEMP_HALF : VOLT_LEN; // R9
        end
      end
      ST_CONV_A: begin
        if (s.timer == '0) begin
          if (s.is_temp) begin
            next_s.first_code = adc_code_i;
            next_s.bias_step  = 1'b1;
            next_s.st         = ST_CONV_B;
            next_s.timer      = TEMP_HALF; // R9
          end else begin
            next_s.word      = {adc_code_i[`CODE_W-1], adc_code_i,
                                adc_sub_lsb_i, 2'b00}; // R5
            next_s.st        = ST_IDLE;
            next_s.strobe_n  = 1'b1; // R8
            next_s.done_tog  = ~s.done_tog;
          end
        end
      end
      ST_CONV_B: begin
        if (s.timer == '0) begin
          // One LSB of the difference is an eighth of a kelvin
          next_s.word      = {2'b00, temp_diff, 2'b00}; // R4 R23
          next_s.st        = ST_IDLE;
          next_s.bias_step = 1'b0;
          next_s.strobe_n  = 1'b1; // R8
          next_s.done_tog  = ~s.done_tog;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase

    if (cmd_evt) begin
      if (cmd_byte[6:3] == `CFG_PREFIX) begin // R13
        next_s.pm      = cmd_byte[`CFG_PM_HI:`CFG_PM_LO]; // R15
        next_s.ref_int = cmd_byte[`CFG_REF_BIT]; // R17
        if (cmd_byte[`CFG_PM_HI:`CFG_PM_LO] == `PM_SHUTDOWN) begin
          next_s.word = '0; // R21
        end
      end else if (cmd_byte[6:4] == `CONV_PREFIX && s.st == ST_IDLE) begin // R14 R7
        sel_temp = (cmd_byte[`CONV_SEL_HI:0] == `SEL_TEMP_INT)
                 | (cmd_byte[`CONV_SEL_HI:0] == `SEL_TEMP_EXT1)
                 | (cmd_byte[`CONV_SEL_HI:0] == `SEL_TEMP_EXT2); // R16
        next_s.sel       = cmd_byte[`CONV_SEL_HI:0];
        next_s.is_temp   = sel_temp;
        next_s.bias_step = 1'b0;
        next_s.strobe_n  = 1'b0; // R8
        if (s.pm == `PM_NORMAL) begin
          next_s.st    = ST_CONV_A;
          next_s.timer = sel_temp ? TEMP_HALF : VOLT_LEN;
        end else begin
          next_s.st = ST_WAKE;
          if (!(s.ref_int | sel_temp)) begin
            next_s.timer = WAKE_LEN; // R19
          end else if (s.pm == `PM_STBY_PLUS) begin
            next_s.timer = WAKE_LEN; // R20
          end else begin
            next_s.timer = WAKE_IREF;
          end
        end
      end
    end

    // Output stage and analog enables follow the next state
    next_s.dout    = next_s.word[`RESULT_BITS-1]; // R10
    next_s.dout_oe = !cs_s; // R12

    busy    = next_s.st != ST_IDLE;
    normal  = next_s.pm == `PM_NORMAL;
    ref_eff = next_s.ref_int | (busy & next_s.is_temp); // R18

    next_s.adc_on       = normal | busy; // R19 R21
    next_s.clk_on       = normal | busy;
    next_s.ref_internal = ref_eff; // R17 R18
    next_s.ref_buf_on   = ref_eff & (normal | busy | (next_s.pm == `PM_STBY_PLUS)); // R20
    next_s.temp_on      = busy ? next_s.is_temp : normal; // R19
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      s            <= '0;
      s.st         <= ST_IDLE;
      s.pm         <= `PM_SHUTDOWN; // R6
      s.sel        <= `SEL_RESET;
      s.strobe_n   <= 1'b1; // R11
    end else begin
      s <= next_s;
    end
  end

  assign dout_o                = s.dout;
  assign dout_oe_o             = s.dout_oe;
  assign conversion_strobe_n_o = s.strobe_n;
  assign power_mode_o          = s.pm;
  assign input_select_o        = s.sel;
  assign adc_on_o              = s.adc_on;
  assign int_clk_on_o          = s.clk_on;
  assign ref_buffer_on_o       = s.ref_buf_on;
  assign ref_internal_o        = s.ref_internal;
  assign temp_circuit_on_o     = s.temp_on;
  assign bias_step_o           = s.bias_step;

endmodule // temp_adc_serial_control

// *** temp_adc_serial_control_assertions.sv ***
`timescale 1ns/1ps
`include "tadc_cfg.svh"

module temp_adc_serial_control_assertions #(
  parameter int unsigned TEMP_CONV_CYCLES = 200,
  parameter int unsigned VOLT_CONV_CYCLES = 100
) (
  input wire logic       sys_clk_i,
  input wire logic       rstn_i,
  input wire logic       sclk_i,
  input wire logic       cs_n_i,
  input wire logic       dout_oe_o,
  input wire logic       conversion_strobe_n_o,
  input wire logic [1:0] power_mode_o,
  input wire logic [3:0] input_select_o,
  input wire logic       adc_on_o,
  input wire logic       int_clk_on_o,
  input wire logic       ref_buffer_on_o,
  input wire logic       ref_internal_o,
  input wire logic       temp_circuit_on_o,
  input wire logic       bias_step_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic [17:0] low_cnt;
  logic        is_temp;
  logic        idle;
  logic        all_off;
  logic        normal;
  assign is_temp = input_select_o inside {4'h7, 4'hC, 4'hD};
  assign idle = conversion_strobe_n_o;
  assign normal = power_mode_o == `PM_NORMAL;
  assign all_off = !(adc_on_o | int_clk_on_o | ref_buffer_on_o | temp_circuit_on_o);
  // Length of the current busy interval
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || conversion_strobe_n_o) low_cnt <= '0;
    else low_cnt <= low_cnt + 18'h1;
  end
  property p_oe_off;
    cs_n_i [*4] |-> !dout_oe_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output enabled while deselected");
  property p_temp_time;
    $rose(conversion_strobe_n_o) && is_temp && normal |->
      low_cnt + 3 >= TEMP_CONV_CYCLES && low_cnt <= TEMP_CONV_CYCLES + 3;
  endproperty
  a_temp_time: assert property (p_temp_time) else $error("temperature busy time wrong");
  property p_volt_time;
    $rose(conversion_strobe_n_o) && !is_temp && normal |->
      low_cnt + 3 >= VOLT_CONV_CYCLES && low_cnt <= VOLT_CONV_CYCLES + 3;
  endproperty
  a_volt_time: assert property (p_volt_time) else $error("voltage busy time wrong");
  property p_sd_off;
    (power_mode_o == `PM_SHUTDOWN && idle) [*3] |-> all_off;
  endproperty
  a_sd_off: assert property (p_sd_off) else $error("function on in shutdown");
  property p_sb_off;
    (power_mode_o == `PM_STANDBY && idle) [*3] |-> all_off;
  endproperty
  a_sb_off: assert property (p_sb_off) else $error("function on in standby");
  property p_sp_buf;
    (power_mode_o == `PM_STBY_PLUS && idle && ref_internal_o) [*3] |->
      ref_buffer_on_o && !adc_on_o && !temp_circuit_on_o;
  endproperty
  a_sp_buf: assert property (p_sp_buf) else $error("standby-plus buffer state wrong");
  property p_temp_ref;
    (!conversion_strobe_n_o && is_temp && normal) [*3] |-> ref_internal_o && temp_circuit_on_o;
  endproperty
  a_temp_ref: assert property (p_temp_ref) else $error("temperature not on internal ref");
  property p_strobe_fall;
    $fell(conversion_strobe_n_o) |-> !sclk_i && !cs_n_i && !$past(sclk_i, 2);
  endproperty
  a_strobe_fall: assert property (p_strobe_fall) else $error("strobe fell off clock low");
  property p_bias;
    $rose(bias_step_o) && normal |-> !conversion_strobe_n_o && is_temp &&
      low_cnt + 3 >= TEMP_CONV_CYCLES / 2 && low_cnt <= TEMP_CONV_CYCLES / 2 + 3;
  endproperty
  a_bias: assert property (p_bias) else $error("bias step out of place");
endmodule // temp_adc_serial_control_assertions

bind temp_adc_serial_control temp_adc_serial_control_assertions #(
  .TEMP_CONV_CYCLES(TEMP_CONV_CYCLES), .VOLT_CONV_CYCLES(VOLT_CONV_CYCLES)
) i_chk (.sys_clk_i, .rstn_i, .sclk_i, .cs_n_i, .dout_oe_o, .conversion_strobe_n_o,
  .power_mode_o, .input_select_o, .adc_on_o, .int_clk_on_o, .ref_buffer_on_o,
  .ref_internal_o, .temp_circuit_on_o, .bias_step_o);

// *** tadc_host.sv ***
`timescale 1ns/1ps

module tadc_host (
  input  wire logic        dout_i,
  input  wire logic        dout_oe_i,
  output logic             sclk_o,
  output logic             cs_n_o,
  output logic             din_o,
  output logic [31:0]      rx_o,
  output logic             rx_vld_o
);
  localparam time HALF = 80;
  initial begin
    sclk_o = 1'b0;
    din_o = 1'b0;
    rx_o = '0;
    rx_vld_o = 1'b0;
    // A late rise of select lets the link's hunt logic see its reset edge
    #1 cs_n_o = 1'b1;
  end
  // Mode 0 frame; the clock idles low outside frames, so it rests while busy
  task automatic frame(input logic [31:0] tx, input int n, input logic flag);
    logic [31:0] r;
    r = '0;
    #33 cs_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      din_o = tx[i];
      #HALF sclk_o = 1'b1;
      r = {r[30:0], dout_oe_i ? dout_i : 1'bx};
      #HALF sclk_o = 1'b0;
    end
    #HALF cs_n_o = 1'b1;
    din_o = ~din_o;
    if (flag) begin
      rx_o = r;
      rx_vld_o = 1'b1;
      #20 rx_vld_o = 1'b0;
    end
  endtask
endmodule // tadc_host

// *** temp_adc_serial_control_tb.sv ***
`timescale 1ns/1ps
`include "tadc_cfg.svh"

module temp_adc_serial_control_tb;
  import tadc_pkg::*;
  logic               sys_clk_i;
  logic               rstn_i;
  logic [`CODE_W-1:0] adc_code_i;
  logic               adc_sub_lsb_i;
  logic               sclk, cs_n, din, dout, dout_oe, strobe_n, rx_vld, ref_int, bias;
  logic [1:0]         pm;
  logic [3:0]         sel_o;
  logic [31:0]        rx;
  logic [23:0]        exp_q[$];
  int                 mismatches = 0;
  int                 num_checks = 0;

  temp_adc_serial_control #(
    .TEMP_CONV_CYCLES(200), .VOLT_CONV_CYCLES(100), .WAKE_CYCLES(20), .WAKE_INTREF_CYCLES(30)
  ) i_dut (
    .sys_clk_i, .rstn_i, .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .adc_code_i,
    .adc_sub_lsb_i, .dout_o(dout), .dout_oe_o(dout_oe), .conversion_strobe_n_o(strobe_n),
    .power_mode_o(pm), .input_select_o(sel_o), .adc_on_o(), .int_clk_on_o(),
    .ref_buffer_on_o(), .ref_internal_o(ref_int), .temp_circuit_on_o(), .bias_step_o(bias)
  );
  tadc_host i_host (
    .dout_i(dout), .dout_oe_i(dout_oe), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
    .rx_o(rx), .rx_vld_o(rx_vld)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wait_strobe(input logic lvl);
    for (int i = 0; i < 2000 && strobe_n !== lvl; i++) @(negedge sys_clk_i);
    chk(32'(strobe_n), 32'(lvl));
  endtask

  // One conversion: optional config, conversion byte, wait, then a 24-bit read
  task automatic conv(input logic [7:0] cfg, input logic [3:0] sel, input logic use_cfg);
    logic [11:0] a;
    logic [11:0] b;
    logic        s;
    a = 12'($urandom);
    b = 12'($urandom);
    s = 1'($urandom);
    @(negedge sys_clk_i);
    adc_code_i = a;
    adc_sub_lsb_i = s;
    if (use_cfg) i_host.frame(32'({2'b00, cfg, 4'hA, sel}), 18, 1'b0);
    else i_host.frame(32'({4'hA, sel}), 8, 1'b0);
    wait_strobe(1'b0);
    if (sel inside {4'h7, 4'hC, 4'hD}) begin
      for (int i = 0; i < 1000 && bias !== 1'b1; i++) @(negedge sys_clk_i);
      @(negedge sys_clk_i);
      adc_code_i = b;
      exp_q.push_back({2'b00, b - a, 2'b00, 8'h00});
    end else begin
      exp_q.push_back({a[11], a, s, 2'b00, 8'h00});
    end
    wait_strobe(1'b1);
    i_host.frame(32'h0, 24, 1'b1);
    chk(32'({pm, ref_int, sel_o}), 32'({cfg[2:1], cfg[0], sel}));
  endtask

  initial forever begin
    @(posedge rx_vld);
    chk(rx, 32'(exp_q.pop_front()));
  end

  initial begin
    #400_000;
    mismatches++;
    final_report();
  end

  initial begin
    rstn_i = 1'b1;
    adc_code_i = '0;
    adc_sub_lsb_i = 1'b0;
    void'($urandom(32'hF788));
    // Reset falls on a clock edge and is held twelve clocks so the core's synchronous reset sees it
    @(negedge sys_clk_i);
    rstn_i = 1'b0;
    repeat (12) @(negedge sys_clk_i);
    chk(32'({pm, strobe_n}), 32'h1);
    rstn_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    for (int k = 0; k < 16; k++) conv(8'h87, 4'(k), k == 0);
    $display("Test input codes done");
    conv(8'h86, 4'h7, 1'b1);
    conv(8'h84, 4'h0, 1'b1);
    conv(8'h85, 4'hC, 1'b1);
    conv(8'h83, 4'hD, 1'b1);
    $display("Test power modes done");
    i_host.frame(32'hB1, 8, 1'b0);
    repeat (10) @(negedge sys_clk_i);
    chk(32'({pm, sel_o, strobe_n}), 32'({2'b01, 4'hD, 1'b1}));
    $display("Test bad byte done");
    conv(8'h87, 4'h9, 1'b1);
    i_host.frame(32'h80, 8, 1'b0);
    repeat (10) @(negedge sys_clk_i);
    exp_q.push_back(24'h0);
    i_host.frame(32'h0, 24, 1'b1);
    repeat (10) @(negedge sys_clk_i);
    $display("Test shutdown done");
    final_report();
  end
endmodule // temp_adc_serial_control_tb
